// [hw/emp_ext_port.v]
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "emp_regs.vh"

// Operation
// (RULE1) four spaces, each with its own select
// (RULE2) per-space memory type and timing fields
// (RULE3) cycle equals fixed plus programmed timing
// (RULE4) sdram join groups 0+1, 2+3, all
// (RULE5) software sets joined spaces to sdram
// (RULE6) posted write acknowledged once data latched
// (RULE7) same-address accesses keep program order
// (RULE8) different addresses may be reordered
// (RULE9) unused ready input held high externally
// (RULE10) sdram signals timed to supplied memory clock
// (RULE11) only one select, for the addressed space; an access to a joined group drives the group's lowest select instead
module emp_ext_port #(
    parameter AW = 24,
    parameter DW = 16
) (
    // clock and reset
    input wire CLK_IN,
    input wire RST_N_IN,
    // apb register port
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    // cpu access port
    input wire CPU_REQ_IN,
    input wire CPU_WR_IN,
    input wire [AW-1:0] CPU_ADDR_IN,
    input wire [DW-1:0] CPU_WDATA_IN,
    output wire CPU_ACK_OUT,
    output reg [DW-1:0] CPU_RDATA_OUT,
    output reg CPU_RVALID_OUT,
    // external memory
    output wire SPACE_SELECT_0_OUT,
    output wire SPACE_SELECT_1_OUT,
    output wire SPACE_SELECT_2_OUT,
    output wire SPACE_SELECT_3_OUT,
    output reg [AW-3:0] MEM_ADDR_OUT,
    output reg [1:0] MEM_BANK_OUT,
    output reg [DW-1:0] MEM_DATA_OUT,
    output reg MEM_DATA_OE_OUT,
    input wire [DW-1:0] MEM_DATA_IN,
    output reg MEM_RD_N_OUT,
    output reg MEM_WE_N_OUT,
    input wire ASYNC_READY_IN,
    // sdram
    output wire SD_CLK_OUT,
    output reg SD_RAS_N_OUT,
    output reg SD_CAS_N_OUT,
    output reg SD_WE_N_OUT
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SETUP = 2'h1;
    localparam ST_STROBE = 2'h2;
    localparam ST_HOLD = 2'h3;
    localparam [31:0] SP_RST = `EMP_SP_RST;

    reg [31:0] ctrl_reg;
    reg [63:0] space_cfg_reg;
    reg [1:0] state_reg;
    reg [4:0] cnt_reg;
    reg [4:0] strobe_reg;
    reg [4:0] hold_reg;
    reg type_reg;
    reg op_wr_reg;
    reg [3:0] sel_reg;
    reg wp_valid_reg;
    reg [AW-1:0] wp_addr_reg;
    reg [DW-1:0] wp_data_reg;
    reg mem_clk_reg;
    reg rdy_q1_reg;
    reg rdy_q2_reg;
    reg rdy_q3_reg;
    reg rdy_reg;
    reg cfg_err_reg;

    wire apb_wr;
    wire apb_hit;
    wire rd_ack;
    wire wr_ack;
    wire same_addr;
    wire launch_rd;
    wire launch_wr;
    wire [AW-1:0] cand_addr;
    wire [3:0] dec_sel;
    wire [1:0] dec_bank;
    wire dec_type;
    wire [4:0] dec_setup;
    wire [4:0] dec_strobe;
    wire [4:0] dec_hold;
    wire dec_err;
    wire tick_now;
    wire tick_cand;

    // apb slave: zero wait states, unmapped offsets answer with an error
    assign apb_hit = (PADDR_IN == `EMP_OFS_CTRL) || (PADDR_IN == `EMP_OFS_SPACE0) ||
        (PADDR_IN == `EMP_OFS_SPACE1) || (PADDR_IN == `EMP_OFS_SPACE2) ||
        (PADDR_IN == `EMP_OFS_SPACE3) || (PADDR_IN == `EMP_OFS_STATUS);
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !apb_hit;
    assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;

    // read data is taken in the setup cycle so it stands through the access phase
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (PSEL_IN && !PENABLE_IN) begin
            case (PADDR_IN)
                `EMP_OFS_CTRL: PRDATA_OUT <= {30'h0, ctrl_reg[1:0]};
                `EMP_OFS_SPACE0: PRDATA_OUT <= {16'h0, space_cfg_reg[15:0]};
                `EMP_OFS_SPACE1: PRDATA_OUT <= {16'h0, space_cfg_reg[31:16]};
                `EMP_OFS_SPACE2: PRDATA_OUT <= {16'h0, space_cfg_reg[47:32]};
                `EMP_OFS_SPACE3: PRDATA_OUT <= {16'h0, space_cfg_reg[63:48]};
                `EMP_OFS_STATUS: PRDATA_OUT <= {28'h0, rdy_reg, cfg_err_reg, wp_valid_reg,
                    (state_reg != ST_IDLE)};
                default: PRDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // each space keeps its own type and timing fields; unused field bits stay zero
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_reg <= `EMP_CTRL_RST;
            space_cfg_reg <= {4{SP_RST[15:0]}};
        end else if (apb_wr) begin
            case (PADDR_IN)
                `EMP_OFS_CTRL: ctrl_reg <= {30'h0, PWDATA_IN[1:0]}; // (RULE4)
                `EMP_OFS_SPACE0: space_cfg_reg[15:0] <= PWDATA_IN[15:0] & 16'hfff1; // (RULE2)
                `EMP_OFS_SPACE1: space_cfg_reg[31:16] <= PWDATA_IN[15:0] & 16'hfff1; // (RULE2)
                `EMP_OFS_SPACE2: space_cfg_reg[47:32] <= PWDATA_IN[15:0] & 16'hfff1; // (RULE2)
                `EMP_OFS_SPACE3: space_cfg_reg[63:48] <= PWDATA_IN[15:0] & 16'hfff1; // (RULE2)
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // ready pin: three stages, a change counts once stages two and three agree
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdy_q1_reg <= 1'b1;
            rdy_q2_reg <= 1'b1;
            rdy_q3_reg <= 1'b1;
            rdy_reg <= 1'b1;
        end else begin
            rdy_q1_reg <= ASYNC_READY_IN; // (RULE9)
            rdy_q2_reg <= rdy_q1_reg;
            rdy_q3_reg <= rdy_q2_reg;
            if (rdy_q2_reg == rdy_q3_reg) begin
                rdy_reg <= rdy_q3_reg;
            end
        end
    end

    // memory clock is half the core clock; sdram outputs move on the edge where it falls,
    // so they are settled half a period before its next rising edge
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mem_clk_reg <= 1'b0;
        end else begin
            mem_clk_reg <= !mem_clk_reg; // (RULE10)
        end
    end
    assign SD_CLK_OUT = mem_clk_reg; // (RULE10)
    assign tick_now = (type_reg == `EMP_TYPE_ASYNC) || mem_clk_reg; // (RULE10)

    // a read to another address may overtake the posted write; a read to the
    // same address waits until that write has gone out
    assign same_addr = wp_valid_reg && (wp_addr_reg == CPU_ADDR_IN); // (RULE7)
    assign launch_rd = CPU_REQ_IN && !CPU_WR_IN && (state_reg == ST_IDLE) && !same_addr; // (RULE8)
    assign cand_addr = launch_rd ? CPU_ADDR_IN : wp_addr_reg;
    assign tick_cand = (dec_type == `EMP_TYPE_ASYNC) || mem_clk_reg;
    assign rd_ack = launch_rd && tick_cand;
    assign launch_wr = !rd_ack && wp_valid_reg && (state_reg == ST_IDLE) && !launch_rd && tick_cand;
    // write is acknowledged as soon as the post slot latches it (RULE6)
    assign wr_ack = CPU_REQ_IN && CPU_WR_IN && !wp_valid_reg; // (RULE6)
    assign CPU_ACK_OUT = wr_ack || rd_ack;

    emp_space_dec u_dec (
        .space_in(cand_addr[AW-1:AW-2]),
        .join_in(ctrl_reg[1:0]),
        .space_cfg_in(space_cfg_reg),
        .sel_out(dec_sel),
        .bank_out(dec_bank),
        .type_out(dec_type),
        .setup_out(dec_setup),
        .strobe_out(dec_strobe),
        .hold_out(dec_hold),
        .cfg_err_out(dec_err)
    );

    assign SPACE_SELECT_0_OUT = sel_reg[0]; // (RULE1)
    assign SPACE_SELECT_1_OUT = sel_reg[1]; // (RULE1)
    assign SPACE_SELECT_2_OUT = sel_reg[2]; // (RULE1)
    assign SPACE_SELECT_3_OUT = sel_reg[3]; // (RULE1)

    // posted write slot: only one write in flight, so no later write can pass it
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wp_valid_reg <= 1'b0;
            wp_addr_reg <= {AW{1'b0}};
            wp_data_reg <= {DW{1'b0}};
        end else if (wr_ack) begin
            wp_valid_reg <= 1'b1; // (RULE6)
            wp_addr_reg <= CPU_ADDR_IN;
            wp_data_reg <= CPU_WDATA_IN;
        end else if ((state_reg == ST_HOLD) && op_wr_reg && tick_now && (cnt_reg == 5'h00)) begin
            wp_valid_reg <= 1'b0;
        end
    end

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 5'h00;
            strobe_reg <= 5'h00;
            hold_reg <= 5'h00;
            type_reg <= `EMP_TYPE_ASYNC;
            op_wr_reg <= 1'b0;
            sel_reg <= 4'h0;
            cfg_err_reg <= 1'b0;
            MEM_ADDR_OUT <= {(AW-2){1'b0}};
            MEM_BANK_OUT <= 2'h0;
            MEM_DATA_OUT <= {DW{1'b0}};
            MEM_DATA_OE_OUT <= 1'b0;
            MEM_RD_N_OUT <= 1'b1;
            MEM_WE_N_OUT <= 1'b1;
            SD_RAS_N_OUT <= 1'b1;
            SD_CAS_N_OUT <= 1'b1;
            SD_WE_N_OUT <= 1'b1;
            CPU_RDATA_OUT <= {DW{1'b0}};
            CPU_RVALID_OUT <= 1'b0;
        end else begin
            CPU_RVALID_OUT <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (rd_ack || launch_wr) begin
                        state_reg <= ST_SETUP;
                        cnt_reg <= dec_setup - 5'h01; // (RULE3)
                        strobe_reg <= dec_strobe;
                        hold_reg <= dec_hold;
                        type_reg <= dec_type;
                        op_wr_reg <= launch_wr;
                        sel_reg <= dec_sel; // (RULE11)
                        cfg_err_reg <= dec_err;
                        MEM_ADDR_OUT <= cand_addr[AW-3:0];
                        MEM_BANK_OUT <= dec_bank; // (RULE4)
                        MEM_DATA_OUT <= wp_data_reg;
                        MEM_DATA_OE_OUT <= launch_wr;
                        if (dec_type == `EMP_TYPE_SDRAM) begin
                            SD_RAS_N_OUT <= 1'b0; // (RULE10)
                        end
                    end
                end
                ST_SETUP: begin
                    if (tick_now) begin
                        SD_RAS_N_OUT <= 1'b1;
                        if (cnt_reg == 5'h00) begin
                            state_reg <= ST_STROBE;
                            cnt_reg <= strobe_reg - 5'h01; // (RULE3)
                            if (type_reg == `EMP_TYPE_SDRAM) begin
                                SD_CAS_N_OUT <= 1'b0; // (RULE10)
                                SD_WE_N_OUT <= !op_wr_reg;
                            end else begin
                                MEM_RD_N_OUT <= op_wr_reg;
                                MEM_WE_N_OUT <= !op_wr_reg;
                            end
                        end else begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end
                    end
                end
                ST_STROBE: begin
                    if (tick_now) begin
                        SD_CAS_N_OUT <= 1'b1;
                        SD_WE_N_OUT <= 1'b1;
                        if (cnt_reg != 5'h00) begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end else if (rdy_reg || (type_reg == `EMP_TYPE_SDRAM)) begin
                            // a low ready only stretches asynchronous strobes
                            state_reg <= ST_HOLD;
                            cnt_reg <= hold_reg - 5'h01; // (RULE3)
                            MEM_RD_N_OUT <= 1'b1;
                            MEM_WE_N_OUT <= 1'b1;
                            CPU_RDATA_OUT <= MEM_DATA_IN;
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick_now) begin
                        if (cnt_reg == 5'h00) begin
                            state_reg <= ST_IDLE;
                            sel_reg <= 4'h0; // (RULE11)
                            MEM_DATA_OE_OUT <= 1'b0;
                            CPU_RVALID_OUT <= !op_wr_reg;
                        end else begin
                            cnt_reg <= cnt_reg - 5'h01;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [hw/emp_regs.vh]
`ifndef EMP_REGS_VH
`define EMP_REGS_VH

// apb register byte offsets
`define EMP_OFS_CTRL 8'h00
`define EMP_OFS_SPACE0 8'h04
`define EMP_OFS_SPACE1 8'h08
`define EMP_OFS_SPACE2 8'h0c
`define EMP_OFS_SPACE3 8'h10
`define EMP_OFS_STATUS 8'h14

// control register: join group field
`define EMP_CTRL_JOIN_LSB 0
`define EMP_CTRL_RST 32'h0000_0000
`define EMP_JOIN_NONE 2'h0
`define EMP_JOIN_01 2'h1
`define EMP_JOIN_23 2'h2
`define EMP_JOIN_ALL 2'h3

// per-space config register fields
`define EMP_SP_TYPE_LSB 0
`define EMP_SP_SETUP_LSB 4
`define EMP_SP_STROBE_LSB 8
`define EMP_SP_HOLD_LSB 12
`define EMP_SP_RST 32'h0000_0000
`define EMP_TYPE_ASYNC 1'h0
`define EMP_TYPE_SDRAM 1'h1

// status register bits
`define EMP_ST_BUSY 0
`define EMP_ST_WPEND 1
`define EMP_ST_CFGERR 2
`define EMP_ST_READY 3

// built-in fixed part of every phase, in ticks
`define EMP_FIX_SETUP 5'h01
`define EMP_FIX_STROBE 5'h01
`define EMP_FIX_HOLD 5'h01

`endif

// [hw/emp_space_dec.v]
`timescale 1ns/1ps
`default_nettype none
`include "emp_regs.vh"

module emp_space_dec (
    // access address space bits
    input wire [1:0] space_in,
    // configuration
    input wire [1:0] join_in,
    input wire [63:0] space_cfg_in,
    // decode results
    output reg [3:0] sel_out,
    output reg [1:0] bank_out,
    output reg type_out,
    output reg [4:0] setup_out,
    output reg [4:0] strobe_out,
    output reg [4:0] hold_out,
    output reg cfg_err_out
);
    reg [15:0] cfg;
    reg [1:0] grp_lo;
    reg joined;

    // total phase length: built-in part plus programmed part
    function [4:0] emp_total;
        input [3:0] prog;
        input [4:0] fix;
        begin
            emp_total = fix + {1'b0, prog};
        end
    endfunction

    always @* begin
        cfg = space_cfg_in[space_in*16 +: 16];
        joined = 1'b0;
        grp_lo = space_in;
        bank_out = 2'h0;
        case (join_in)
            `EMP_JOIN_01: begin
                if (!space_in[1]) begin
                    joined = 1'b1;
                    grp_lo = 2'h0;
                    bank_out = {1'b0, space_in[0]};
                end
            end
            `EMP_JOIN_23: begin
                if (space_in[1]) begin
                    joined = 1'b1;
                    grp_lo = 2'h2;
                    bank_out = {1'b0, space_in[0]};
                end
            end
            `EMP_JOIN_ALL: begin
                joined = 1'b1;
                grp_lo = 2'h0;
                bank_out = space_in;
            end
            default: begin
                joined = 1'b0;
            end
        endcase
        // a joined group is one sdram region behind the group's lowest select (RULE4)
        sel_out = 4'h1 << grp_lo; // (RULE11)
        type_out = cfg[`EMP_SP_TYPE_LSB]; // (RULE2)
        // software must mark every joined space as sdram; flag it when not
        cfg_err_out = 1'b0;
        if (joined) begin
            case (join_in)
                `EMP_JOIN_01: cfg_err_out = !(space_cfg_in[0] && space_cfg_in[16]); // (RULE5)
                `EMP_JOIN_23: cfg_err_out = !(space_cfg_in[32] && space_cfg_in[48]); // (RULE5)
                default: cfg_err_out = !(space_cfg_in[0] && space_cfg_in[16] &&
                    space_cfg_in[32] && space_cfg_in[48]); // (RULE5)
            endcase
            type_out = `EMP_TYPE_SDRAM;
        end
        setup_out = emp_total(cfg[`EMP_SP_SETUP_LSB +: 4], `EMP_FIX_SETUP); // (RULE3)
        strobe_out = emp_total(cfg[`EMP_SP_STROBE_LSB +: 4], `EMP_FIX_STROBE); // (RULE3)
        hold_out = emp_total(cfg[`EMP_SP_HOLD_LSB +: 4], `EMP_FIX_HOLD); // (RULE3)
    end
endmodule
`default_nettype wire

// [tb/emp_ext_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module emp_ext_port_assertions (
    // clock and reset
    input wire CLK_IN,
    input wire RST_N_IN,
    // cpu side
    input wire CPU_REQ_IN,
    input wire CPU_ACK_OUT,
    // external side
    input wire SPACE_SELECT_0_OUT,
    input wire SPACE_SELECT_1_OUT,
    input wire SPACE_SELECT_2_OUT,
    input wire SPACE_SELECT_3_OUT,
    input wire [1:0] MEM_BANK_OUT,
    input wire MEM_DATA_OE_OUT,
    input wire MEM_RD_N_OUT,
    input wire MEM_WE_N_OUT,
    input wire SD_CLK_OUT,
    input wire SD_RAS_N_OUT,
    input wire SD_CAS_N_OUT
);
    wire [3:0] sel = {SPACE_SELECT_3_OUT, SPACE_SELECT_2_OUT, SPACE_SELECT_1_OUT, SPACE_SELECT_0_OUT};
    wire sel_any = |sel;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    a_one_select: assert property ($onehot0(sel)) else $error("two space selects high");
    a_ack_req: assert property (CPU_ACK_OUT |-> CPU_REQ_IN) else $error("ack without request");
    a_rd_framed: assert property (!MEM_RD_N_OUT |-> sel_any && !MEM_DATA_OE_OUT) else $error("read strobe unframed");
    a_we_framed: assert property (!MEM_WE_N_OUT |-> sel_any && MEM_DATA_OE_OUT) else $error("write strobe unframed");
    a_setup_first: assert property ($fell(MEM_RD_N_OUT) || $fell(MEM_WE_N_OUT) |-> $past(sel_any))
        else $error("strobe without setup");
    a_hold_last: assert property ($fell(sel_any) |-> $past(MEM_RD_N_OUT) && $past(MEM_WE_N_OUT))
        else $error("select dropped without hold");
    a_memclk_runs: assert property ($past(RST_N_IN) |-> SD_CLK_OUT != $past(SD_CLK_OUT))
        else $error("memory clock stalled");
    a_ras_one_clk: assert property ($fell(SD_RAS_N_OUT) |=> !SD_RAS_N_OUT ##1 SD_RAS_N_OUT)
        else $error("row command not one memory clock");
    a_cas_framed: assert property (!SD_CAS_N_OUT |-> sel_any) else $error("column command unframed");
    a_bank_join: assert property (sel_any && MEM_BANK_OUT != 2'h0 |-> SPACE_SELECT_0_OUT || SPACE_SELECT_2_OUT)
        else $error("bank bits outside joined group");
endmodule

bind emp_ext_port emp_ext_port_assertions u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CPU_REQ_IN(CPU_REQ_IN),
    .CPU_ACK_OUT(CPU_ACK_OUT), .SPACE_SELECT_0_OUT(SPACE_SELECT_0_OUT), .SPACE_SELECT_1_OUT(SPACE_SELECT_1_OUT),
    .SPACE_SELECT_2_OUT(SPACE_SELECT_2_OUT), .SPACE_SELECT_3_OUT(SPACE_SELECT_3_OUT), .MEM_BANK_OUT(MEM_BANK_OUT),
    .MEM_DATA_OE_OUT(MEM_DATA_OE_OUT), .MEM_RD_N_OUT(MEM_RD_N_OUT), .MEM_WE_N_OUT(MEM_WE_N_OUT),
    .SD_CLK_OUT(SD_CLK_OUT), .SD_RAS_N_OUT(SD_RAS_N_OUT), .SD_CAS_N_OUT(SD_CAS_N_OUT));

`default_nettype wire

// [tb/emp_ext_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "emp_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h want %h", $time, a, b); end end

module emp_ext_port_tb;
    localparam int BASE = 1 + `EMP_FIX_SETUP + `EMP_FIX_STROBE + `EMP_FIX_HOLD;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, req = 0, wr = 0, stall = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [23:0] caddr = 0;
    logic [15:0] cwdata = 0, d;
    logic [3:0] s;
    logic [1:0] b;
    logic e, f;
    int n, errors = 0, check_count = 0;
    wire [31:0] prdata;
    wire [21:0] maddr;
    wire [15:0] rdata, mdo, mdi;
    wire [3:0] sel;
    wire [1:0] bank;
    wire pready, pslverr, ack, rvalid, oe, rd_n, we_n, rdy, sdclk, ras_n, cas_n, sdwe_n;

    emp_ext_port u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .CPU_REQ_IN(req), .CPU_WR_IN(wr), .CPU_ADDR_IN(caddr), .CPU_WDATA_IN(cwdata), .CPU_ACK_OUT(ack),
        .CPU_RDATA_OUT(rdata), .CPU_RVALID_OUT(rvalid), .SPACE_SELECT_0_OUT(sel[0]), .SPACE_SELECT_1_OUT(sel[1]),
        .SPACE_SELECT_2_OUT(sel[2]), .SPACE_SELECT_3_OUT(sel[3]), .MEM_ADDR_OUT(maddr), .MEM_BANK_OUT(bank),
        .MEM_DATA_OUT(mdo), .MEM_DATA_OE_OUT(oe), .MEM_DATA_IN(mdi), .MEM_RD_N_OUT(rd_n), .MEM_WE_N_OUT(we_n),
        .ASYNC_READY_IN(rdy), .SD_CLK_OUT(sdclk), .SD_RAS_N_OUT(ras_n), .SD_CAS_N_OUT(cas_n), .SD_WE_N_OUT(sdwe_n));
    emp_mem_model u_mem (.clk_in(clk), .sel_in(sel), .addr_in(maddr[3:0]), .bank_in(bank), .data_in(mdo),
        .rd_n_in(rd_n), .we_n_in(we_n), .cas_n_in(cas_n), .sd_we_n_in(sdwe_n), .stall_in(stall),
        .data_out(mdi), .ready_out(rdy));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic cpu_wr(input logic [23:0] a, input logic [15:0] wd);
        @(posedge clk);
        req <= 1'b1;
        wr <= 1'b1;
        caddr <= a;
        cwdata <= wd;
        @(negedge clk);
        f = ack;
        while (ack !== 1'b1) @(negedge clk);
        @(posedge clk);
        req <= 1'b0;
        wr <= 1'b0;
    endtask

    // counts cycles from the taking edge and records selects seen meanwhile
    task automatic cpu_rd(input logic [23:0] a);
        @(posedge clk);
        req <= 1'b1;
        caddr <= a;
        do @(negedge clk); while (ack !== 1'b1);
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        s = 4'h0;
        b = 2'h0;
        do begin
            @(negedge clk);
            n++;
            s |= sel;
            if (|sel) b |= bank;
        end while (rvalid !== 1'b1);
        d = rdata;
    endtask

    task automatic t_regs;
        apb(1'b0, `EMP_OFS_CTRL, 32'h0);
        `CHK(r, `EMP_CTRL_RST)
        apb(1'b1, `EMP_OFS_SPACE2, 32'hffff);
        apb(1'b0, `EMP_OFS_SPACE2, 32'h0);
        `CHK(r, 32'h0000fff1)
        apb(1'b1, `EMP_OFS_SPACE2, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        `CHK({e, r}, 33'h100000000)
    endtask

    task automatic t_spaces;
        for (int i = 0; i < 4; i++) begin
            cpu_rd({i[1:0], 22'h5});
            `CHK(d, {8'ha5, i[1:0], 6'h05})
            `CHK(s, 4'h1 << i)
            `CHK(n, BASE)
        end
    endtask

    task automatic t_timing;
        apb(1'b1, `EMP_OFS_SPACE2, 32'h1320);
        cpu_rd({2'h2, 22'h1});
        `CHK(n, BASE + 6)
        `CHK(d, 16'ha581)
        apb(1'b1, `EMP_OFS_SPACE2, 32'h0);
    endtask

    task automatic t_posted;
        cpu_wr({2'h1, 22'h2}, 16'hbeef);
        `CHK(f, 1'b1)
        @(negedge clk);
        `CHK(we_n, 1'b1)
        apb(1'b0, `EMP_OFS_STATUS, 32'h0);
        `CHK(r[`EMP_ST_WPEND], 1'b1)
        cpu_rd({2'h1, 22'h2});
        `CHK(d, 16'hbeef)
        cpu_wr({2'h3, 22'h4}, 16'h1234);
        cpu_rd({2'h0, 22'h4});
        `CHK(d, 16'ha504)
        cpu_rd({2'h3, 22'h4});
        `CHK(d, 16'h1234)
    endtask

    task automatic t_ready;
        apb(1'b1, `EMP_OFS_SPACE3, 32'h0400);
        stall <= 1'b1;
        cpu_rd({2'h3, 22'h6});
        stall <= 1'b0;
        `CHK(n > BASE + 4, 1'b1)
        `CHK(d, 16'ha5c6)
        apb(1'b1, `EMP_OFS_SPACE3, 32'h0);
    endtask

    // one row per join group: space read, select seen, bank, stored value
    task automatic t_sdram;
        logic [23:0] ra [3] = '{24'h400000, 24'hc00000, 24'hc00000};
        logic [3:0] rs [3] = '{4'h1, 4'h4, 4'h1};
        logic [1:0] rb [3] = '{2'h1, 2'h1, 2'h3};
        logic [15:0] rd [3] = '{16'ha510, 16'ha590, 16'ha530};
        for (int k = 0; k < 4; k++) apb(1'b1, `EMP_OFS_SPACE0 + 8'(4 * k), 32'h1);
        for (int j = 0; j < 3; j++) begin
            apb(1'b1, `EMP_OFS_CTRL, 32'(j + 1));
            cpu_rd(ra[j]);
            `CHK({d, s, b}, {rd[j], rs[j], rb[j]})
        end
        apb(1'b1, `EMP_OFS_CTRL, 32'(`EMP_JOIN_01));
        cpu_wr({2'h1, 22'h3}, 16'hcafe);
        cpu_rd({2'h1, 22'h3});
        `CHK(d, 16'hcafe)
        cpu_rd({2'h0, 22'h3});
        `CHK({d, b}, {16'ha503, 2'h0})
    endtask

    task automatic stop_test;
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial forever #4 clk = ~clk;

    // whole run needs a few hundred cycles
    initial begin
        #200000;
        errors++;
        stop_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_spaces;
        t_timing;
        t_posted;
        t_ready;
        t_sdram;
        stop_test;
    end
endmodule

`default_nettype wire

// [tb/emp_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module emp_mem_model (
    // clock
    input wire logic clk_in,
    // external bus
    input wire logic [3:0] sel_in,
    input wire logic [3:0] addr_in,
    input wire logic [1:0] bank_in,
    input wire logic [15:0] data_in,
    input wire logic rd_n_in,
    input wire logic we_n_in,
    input wire logic cas_n_in,
    input wire logic sd_we_n_in,
    // test control
    input wire logic stall_in,
    output logic [15:0] data_out,
    output logic ready_out
);
    logic [15:0] mem [256];
    logic [15:0] last_q = 16'h0;
    logic sd_rd = 1'b0;
    logic [3:0] cnt = 4'h0;
    wire [1:0] idx = sel_in[1] ? 2'h1 : sel_in[2] ? 2'h2 : sel_in[3] ? 2'h3 : 2'h0;
    wire [7:0] key = {idx, bank_in, addr_in};

    initial for (int i = 0; i < 256; i++) mem[i] = {8'ha5, i[7:0]};
    // released bus shows inverted last value so stale data cannot pass
    assign data_out = (!rd_n_in || sd_rd) ? mem[key] : ~last_q;
    // ready is always driven, low only while a stall is asked for
    assign ready_out = !(stall_in && |sel_in && cnt < 4'hc);
    always @(posedge clk_in) begin
        last_q <= data_out;
        if (!we_n_in || (!cas_n_in && !sd_we_n_in)) begin
            mem[key] <= data_in;
        end
        if (!cas_n_in && sd_we_n_in) begin
            sd_rd <= 1'b1;
        end else if (!(|sel_in)) begin
            sd_rd <= 1'b0;
        end
        cnt <= (|sel_in) ? ((cnt == 4'hc) ? cnt : cnt + 4'h1) : 4'h0;
    end
endmodule

`default_nettype wire
